// *** core/idc_defines.vh ***
// Field positions, encodings and register map of the instruction decoder
`ifndef IDC_DEFINES_VH
`define IDC_DEFINES_VH

`define IDC_PFX_RNG   13:12
`define IDC_OPC_RNG   11:8
`define IDC_DBIT      7
`define IDC_FADR_RNG  6:0
`define IDC_BSUB_RNG  11:10
`define IDC_BPOS_RNG  9:7
`define IDC_LIT_RNG   7:0
`define IDC_TGT_RNG   10:0
`define IDC_JBIT      11
`define IDC_LADD_RNG  11:9

`define IDC_CLS_BYTE  2'h0
`define IDC_CLS_BIT   2'h1
`define IDC_CLS_CTL   2'h2
`define IDC_CLS_LIT   2'h3

`define IDC_OPC_MISC  4'h0
`define IDC_OPC_CLR   4'h1
`define IDC_OPC_SUB   4'h2
`define IDC_OPC_DEC   4'h3
`define IDC_OPC_OR    4'h4
`define IDC_OPC_AND   4'h5
`define IDC_OPC_XOR   4'h6
`define IDC_OPC_ADD   4'h7
`define IDC_OPC_MOV   4'h8
`define IDC_OPC_COM   4'h9
`define IDC_OPC_INC   4'ha
`define IDC_OPC_DECSZ 4'hb
`define IDC_OPC_RRC   4'hc
`define IDC_OPC_RLC   4'hd
`define IDC_OPC_SWAP  4'he
`define IDC_OPC_INCSZ 4'hf

`define IDC_LOPC_OR   4'h8
`define IDC_LOPC_AND  4'h9
`define IDC_LOPC_XOR  4'ha
`define IDC_LOPC_SUB  3'h6
`define IDC_LOPC_ADD  3'h7
`define IDC_LSUB_LOAD 2'h0
`define IDC_LSUB_RET  2'h1

`define IDC_W_NOP     14'h0000
`define IDC_W_SLEEP   14'h0063
`define IDC_W_WATCHDOG_CLEAR_OP  14'h0064
`define IDC_W_RETURN  14'h0008
`define IDC_W_RETFIE  14'h0009
`define IDC_W_CLRW    14'h0103

`define IDC_OP_NOP    5'h00
`define IDC_OP_OR     5'h01
`define IDC_OP_AND    5'h02
`define IDC_OP_XOR    5'h03
`define IDC_OP_RLC    5'h04
`define IDC_OP_RRC    5'h05
`define IDC_OP_DEC    5'h06
`define IDC_OP_INC    5'h07
`define IDC_OP_BCLR   5'h08
`define IDC_OP_BSET   5'h09
`define IDC_OP_BTST   5'h0a
`define IDC_OP_LOAD   5'h0b
`define IDC_OP_SUBL   5'h0c
`define IDC_OP_ADDL   5'h0d
`define IDC_OP_ADD    5'h0e
`define IDC_OP_SUB    5'h0f
`define IDC_OP_CLR    5'h10
`define IDC_OP_COM    5'h11
`define IDC_OP_MOVF   5'h12
`define IDC_OP_MOVWF  5'h13
`define IDC_OP_SWAP   5'h14
`define IDC_OP_CALL   5'h15
`define IDC_OP_JUMP   5'h16
`define IDC_OP_RET    5'h17
`define IDC_OP_RETFIE 5'h18
`define IDC_OP_SLEEP  5'h19
`define IDC_OP_WDCLR  5'h1a

`define IDC_FLG_NONE  4'h0
`define IDC_FLG_Z     4'h1
`define IDC_FLG_C     4'h4
`define IDC_FLG_CDCZ  4'h7
`define IDC_FLG_TOPD  4'h8

`define IDC_SKP_NONE  2'h0
`define IDC_SKP_ZERO  2'h1
`define IDC_SKP_BCLR  2'h2
`define IDC_SKP_BSET  2'h3

`define IDC_RA_CTRL   4'h0
`define IDC_RA_TMR    4'h1
`define IDC_RA_PORTA  4'h2
`define IDC_RA_PORTB  4'h3
`define IDC_RA_STAT   4'h4
`define IDC_RA_COUNT  4'h5

`define IDC_CTRL_RST  1'h0
`define IDC_TMR_RST   7'h01
`define IDC_PORTA_RST 7'h05
`define IDC_PORTB_RST 7'h06

`endif

// *** core/idc_reset_sync.v ***
// Reset release synchroniser for the decoder
`timescale 1ns/10ps
`default_nettype none
module idc_reset_sync
(
  // Clock and raw reset
  input  wire core_clk,
  input  wire reset_n,
  // Synchronised reset
  output reg  rst_sync_n
);

  reg meta_n_reg;

  // Assert at once, release only on a clock edge to avoid a ragged release
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_n_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      meta_n_reg <= 1'b1;
      rst_sync_n <= meta_n_reg;
    end
  end

endmodule // idc_reset_sync
`default_nettype wire

// *** core/idc_decoder.v ***
// Instruction decoder for the 14-bit instruction word of the 8-bit core
//
// Summary of operation
// - Byte OR/AND/XOR decode, zero flag only
// - Byte rotates through carry, carry only
// - Decrement, skip on zero, no flags
// - Increment, skip on zero, no flags
// - Bit clear/set, no status flags
// - Bit tests skip when clear or set
// - Literal OR/AND/XOR into accumulator, zero only
// - Literal subtract and add update C, DC, Z
// - Literal load; return with literal, two cycles
// - Standby and watchdog clear update timeout, powerdown
// - Program counter change or true test: two cycles
// - Timer zero write clears assigned prescaler
// - Port read-modify-write reads pin levels
// - Destination bit selects accumulator or file
`include "idc_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module idc_decoder
#(
  parameter ADDR_W = 4,
  parameter DATA_W = 32,
  parameter [6:0] TMR_ADDR_RST   = `IDC_TMR_RST,
  parameter [6:0] PORTA_ADDR_RST = `IDC_PORTA_RST,
  parameter [6:0] PORTB_ADDR_RST = `IDC_PORTB_RST
)
(
  // Clock and reset
  input  wire              core_clk,
  input  wire              reset_n,
  // Program memory side
  input  wire [13:0]       instr_word,
  input  wire              instr_valid,
  // Datapath feedback
  input  wire              skip_taken,
  // Decoded instruction
  output reg               op_valid,
  output reg  [4:0]        op_code,
  output reg  [1:0]        op_class,
  output reg               dest_file,
  output reg  [6:0]        file_addr,
  output reg  [2:0]        bit_pos,
  output reg  [7:0]        literal,
  output reg  [10:0]       target_addr,
  output reg  [3:0]        flag_update,
  output reg  [1:0]        skip_cond,
  output reg               two_cycle,
  output reg               flush_nop,
  output reg               prescaler_clear,
  output reg               use_pin_level,
  // Register port
  input  wire [ADDR_W-1:0] reg_addr,
  input  wire [DATA_W-1:0] reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [DATA_W-1:0] reg_rdata
);

  localparam ST_EXEC  = 1'b0;
  localparam ST_FLUSH = 1'b1;

  wire rst_n;

  reg        state_reg;
  reg        state_next;
  reg        presc_assign_reg;
  reg [6:0]  tmr_addr_reg;
  reg [6:0]  porta_addr_reg;
  reg [6:0]  portb_addr_reg;
  reg [15:0] count_reg;
  reg [7:0]  squash_cnt_reg;

  reg [13:0] word;
  reg [4:0]  op_next;
  reg        dest_next;
  reg [3:0]  flg_next;
  reg [1:0]  skp_next;
  reg        two_next;
  reg        wrf_next;
  reg        rmw_next;
  reg        squash;
  reg        squash_now;
  reg [DATA_W-1:0] rd_next;

  function addr_hit;
    input [6:0] a;
    input [6:0] b;
    begin
      addr_hit = (a == b);
    end
  endfunction

  idc_reset_sync u_rst
  (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .rst_sync_n (rst_n)
  );

  // Current instruction needs a second, idle cycle
  always @*
  begin
    squash_now = op_valid & (two_cycle |
                 ((skip_cond != `IDC_SKP_NONE) & skip_taken));
    squash = squash_now | (state_reg == ST_FLUSH);
  end

  always @*
  begin
    case (state_reg)
      ST_EXEC:
        state_next = (squash_now & ~instr_valid) ? ST_FLUSH : ST_EXEC;
      ST_FLUSH:
        state_next = instr_valid ? ST_EXEC : ST_FLUSH;
      default:
        state_next = ST_EXEC;
    endcase
  end

  // Word squashed into the idle cycle is decoded as a plain no-op
  always @*
  begin
    word      = (squash | ~instr_valid) ? `IDC_W_NOP : instr_word;
    op_next   = `IDC_OP_NOP;
    dest_next = 1'b0;
    flg_next  = `IDC_FLG_NONE;
    skp_next  = `IDC_SKP_NONE;
    two_next  = 1'b0;
    wrf_next  = 1'b0;
    rmw_next  = 1'b0;
    case (word[`IDC_PFX_RNG])
      `IDC_CLS_BYTE:
      begin
        dest_next = word[`IDC_DBIT];
        wrf_next  = word[`IDC_DBIT];
        rmw_next  = word[`IDC_DBIT];
        case (word[`IDC_OPC_RNG])
          `IDC_OPC_MISC:
          begin
            rmw_next = 1'b0;
            if (word[`IDC_DBIT])
              op_next = `IDC_OP_MOVWF;
            else if (word == `IDC_W_SLEEP)
              {op_next, flg_next} = {`IDC_OP_SLEEP, `IDC_FLG_TOPD};
            else if (word == `IDC_W_WATCHDOG_CLEAR_OP)
              {op_next, flg_next} = {`IDC_OP_WDCLR, `IDC_FLG_TOPD};
            else if (word == `IDC_W_RETURN)
              {op_next, two_next} = {`IDC_OP_RET, 1'b1};
            else if (word == `IDC_W_RETFIE)
              {op_next, two_next} = {`IDC_OP_RETFIE, 1'b1};
            else
              op_next = `IDC_OP_NOP;
          end
          `IDC_OPC_CLR:
          begin
            rmw_next = 1'b0;
            if (word[`IDC_DBIT] || word == `IDC_W_CLRW)
              {op_next, flg_next} = {`IDC_OP_CLR, `IDC_FLG_Z};
          end
          `IDC_OPC_OR:
            {op_next, flg_next} = {`IDC_OP_OR, `IDC_FLG_Z};
          `IDC_OPC_AND:
            {op_next, flg_next} = {`IDC_OP_AND, `IDC_FLG_Z};
          `IDC_OPC_XOR:
            {op_next, flg_next} = {`IDC_OP_XOR, `IDC_FLG_Z};
          `IDC_OPC_RLC:
            {op_next, flg_next} = {`IDC_OP_RLC, `IDC_FLG_C};
          `IDC_OPC_RRC:
            {op_next, flg_next} = {`IDC_OP_RRC, `IDC_FLG_C};
          `IDC_OPC_DECSZ:
            {op_next, skp_next} = {`IDC_OP_DEC, `IDC_SKP_ZERO};
          `IDC_OPC_INCSZ:
            {op_next, skp_next} = {`IDC_OP_INC, `IDC_SKP_ZERO};
          `IDC_OPC_DEC:
            {op_next, flg_next} = {`IDC_OP_DEC, `IDC_FLG_Z};
          `IDC_OPC_INC:
            {op_next, flg_next} = {`IDC_OP_INC, `IDC_FLG_Z};
          `IDC_OPC_ADD:
            {op_next, flg_next} = {`IDC_OP_ADD, `IDC_FLG_CDCZ};
          `IDC_OPC_SUB:
            {op_next, flg_next} = {`IDC_OP_SUB, `IDC_FLG_CDCZ};
          `IDC_OPC_MOV:
            {op_next, flg_next} = {`IDC_OP_MOVF, `IDC_FLG_Z};
          `IDC_OPC_COM:
            {op_next, flg_next} = {`IDC_OP_COM, `IDC_FLG_Z};
          `IDC_OPC_SWAP:
            op_next = `IDC_OP_SWAP;
          default:
            op_next = `IDC_OP_NOP;
        endcase
      end
      `IDC_CLS_BIT:
      begin
        case (word[`IDC_BSUB_RNG])
          2'h0:
          begin
            op_next   = `IDC_OP_BCLR;
            dest_next = 1'b1;
            wrf_next  = 1'b1;
            rmw_next  = 1'b1;
          end
          2'h1:
          begin
            op_next   = `IDC_OP_BSET;
            dest_next = 1'b1;
            wrf_next  = 1'b1;
            rmw_next  = 1'b1;
          end
          2'h2:
          begin
            op_next  = `IDC_OP_BTST;
            skp_next = `IDC_SKP_BCLR;
          end
          default:
          begin
            op_next  = `IDC_OP_BTST;
            skp_next = `IDC_SKP_BSET;
          end
        endcase
      end
      `IDC_CLS_CTL:
      begin
        op_next  = word[`IDC_JBIT] ? `IDC_OP_JUMP : `IDC_OP_CALL;
        two_next = 1'b1;
      end
      default:
      begin
        if (word[`IDC_BSUB_RNG] == `IDC_LSUB_LOAD)
          op_next = `IDC_OP_LOAD;
        else if (word[`IDC_BSUB_RNG] == `IDC_LSUB_RET)
          {op_next, two_next} = {`IDC_OP_RET, 1'b1};
        else if (word[`IDC_OPC_RNG] == `IDC_LOPC_OR)
          {op_next, flg_next} = {`IDC_OP_OR, `IDC_FLG_Z};
        else if (word[`IDC_OPC_RNG] == `IDC_LOPC_AND)
          {op_next, flg_next} = {`IDC_OP_AND, `IDC_FLG_Z};
        else if (word[`IDC_OPC_RNG] == `IDC_LOPC_XOR)
          {op_next, flg_next} = {`IDC_OP_XOR, `IDC_FLG_Z};
        else if (word[`IDC_LADD_RNG] == `IDC_LOPC_SUB)
          {op_next, flg_next} = {`IDC_OP_SUBL, `IDC_FLG_CDCZ};
        else if (word[`IDC_LADD_RNG] == `IDC_LOPC_ADD)
          {op_next, flg_next} = {`IDC_OP_ADDL, `IDC_FLG_CDCZ};
        else
          op_next = `IDC_OP_NOP;
      end
    endcase
  end

  // Decoded outputs, all registered
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg       <= ST_EXEC;
      op_valid        <= 1'b0;
      op_code         <= `IDC_OP_NOP;
      op_class        <= `IDC_CLS_BYTE;
      dest_file       <= 1'b0;
      file_addr       <= 7'h00;
      bit_pos         <= 3'h0;
      literal         <= 8'h00;
      target_addr     <= 11'h000;
      flag_update     <= `IDC_FLG_NONE;
      skip_cond       <= `IDC_SKP_NONE;
      two_cycle       <= 1'b0;
      flush_nop       <= 1'b0;
      prescaler_clear <= 1'b0;
      use_pin_level   <= 1'b0;
    end
    else
    begin
      state_reg       <= state_next;
      op_valid        <= instr_valid;
      op_code         <= op_next;
      op_class        <= word[`IDC_PFX_RNG];
      dest_file       <= dest_next;
      file_addr       <= word[`IDC_FADR_RNG];
      bit_pos         <= word[`IDC_BPOS_RNG];
      literal         <= word[`IDC_LIT_RNG];
      target_addr     <= word[`IDC_TGT_RNG];
      flag_update     <= flg_next;
      skip_cond       <= skp_next;
      two_cycle       <= two_next;
      flush_nop       <= instr_valid & squash;
      // Only writes into the timer count the prescaler clear
      prescaler_clear <= presc_assign_reg & wrf_next &
                         addr_hit(word[`IDC_FADR_RNG], tmr_addr_reg);
      // Port latches may disagree with pins; modify uses the pins
      use_pin_level   <= rmw_next &
                         (addr_hit(word[`IDC_FADR_RNG], porta_addr_reg) |
                          addr_hit(word[`IDC_FADR_RNG], portb_addr_reg));
    end
  end

  // Configuration registers and statistics
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_assign_reg <= `IDC_CTRL_RST;
      tmr_addr_reg     <= TMR_ADDR_RST;
      porta_addr_reg   <= PORTA_ADDR_RST;
      portb_addr_reg   <= PORTB_ADDR_RST;
      count_reg        <= 16'h0000;
      squash_cnt_reg   <= 8'h00;
    end
    else
    begin
      if (reg_wr && reg_addr == `IDC_RA_CTRL)
        presc_assign_reg <= reg_wdata[0];
      if (reg_wr && reg_addr == `IDC_RA_TMR)
        tmr_addr_reg <= reg_wdata[`IDC_FADR_RNG];
      if (reg_wr && reg_addr == `IDC_RA_PORTA)
        porta_addr_reg <= reg_wdata[`IDC_FADR_RNG];
      if (reg_wr && reg_addr == `IDC_RA_PORTB)
        portb_addr_reg <= reg_wdata[`IDC_FADR_RNG];
      // Counters wrap; a write of any value clears them
      if (reg_wr && reg_addr == `IDC_RA_COUNT)
        count_reg <= 16'h0000;
      else if (instr_valid && !squash)
        count_reg <= count_reg + 16'h0001;
      if (reg_wr && reg_addr == `IDC_RA_COUNT)
        squash_cnt_reg <= 8'h00;
      else if (instr_valid && squash)
        squash_cnt_reg <= squash_cnt_reg + 8'h01;
    end
  end

  always @*
  begin
    rd_next = {DATA_W{1'b0}};
    case (reg_addr)
      `IDC_RA_CTRL:  rd_next[0] = presc_assign_reg;
      `IDC_RA_TMR:   rd_next[6:0] = tmr_addr_reg;
      `IDC_RA_PORTA: rd_next[6:0] = porta_addr_reg;
      `IDC_RA_PORTB: rd_next[6:0] = portb_addr_reg;
      `IDC_RA_STAT:  rd_next[10:0] = {state_reg, squash_cnt_reg, op_class};
      `IDC_RA_COUNT: rd_next[15:0] = count_reg;
      default:       rd_next = {DATA_W{1'b0}};
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= {DATA_W{1'b0}};
    else
      reg_rdata <= reg_rd ? rd_next : {DATA_W{1'b0}};
  end

endmodule // idc_decoder
`default_nettype wire

// *** verification/idc_pmem_model.sv ***
// Behavioural program memory feeding instruction words
`timescale 1ns/10ps
`default_nettype none
module idc_pmem_model
(
  // Clock and requests from the bench
  input  wire logic        core_clk,
  input  wire logic        slow,
  input  wire logic        req,
  input  wire logic [13:0] req_word,
  // Word stream into the decoder
  output var  logic        instr_valid = 1'h0,
  output var  logic [13:0] instr_word = 14'h0
);
  logic        hold_v = 1'h0;
  logic [13:0] hold_w;
  // Slow fetch costs one cycle; an idle bus shows inverted stale data, never a held word
  always @(posedge core_clk)
  begin
    hold_v      <= req & slow;
    hold_w      <= req_word;
    instr_valid <= (req & ~slow) | hold_v;
    if (req & ~slow)
      instr_word <= req_word;
    else if (hold_v)
      instr_word <= hold_w;
    else
      instr_word <= ~instr_word;
  end
endmodule // idc_pmem_model
`default_nettype wire

// *** verification/idc_decoder_assertions.sv ***
// Concurrent checks on the decoder ports
`timescale 1ns/10ps
`default_nettype none
`include "idc_defines.vh"
module idc_decoder_checker
#(
  parameter DATA_W = 32
)
(
  // Clock, reset and inputs
  input wire logic              core_clk, reset_n, instr_valid, skip_taken, reg_rd,
  input wire logic [13:0]       instr_word,
  // Decoded outputs
  input wire logic              op_valid, two_cycle, flush_nop, dest_file,
  input wire logic [4:0]        op_code,
  input wire logic [3:0]        flag_update,
  input wire logic [1:0]        skip_cond,
  input wire logic [DATA_W-1:0] reg_rdata
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  a_logic_zero_only:
    assert property (op_valid && op_code inside {`IDC_OP_OR, `IDC_OP_AND, `IDC_OP_XOR}
      |-> flag_update == `IDC_FLG_Z) else $error("logic op flag mask wrong");
  a_rotate_carry_only:
    assert property (op_valid && op_code inside {`IDC_OP_RLC, `IDC_OP_RRC}
      |-> flag_update == `IDC_FLG_C) else $error("rotate flag mask wrong");
  a_skip_no_flags:
    assert property (op_valid && skip_cond == `IDC_SKP_ZERO
      |-> flag_update == `IDC_FLG_NONE) else $error("zero skip changes flags");
  a_bit_no_flags:
    assert property (op_valid && op_code inside {`IDC_OP_BCLR, `IDC_OP_BSET}
      |-> flag_update == `IDC_FLG_NONE) else $error("bit op changes flags");
  a_bit_skip_kind:
    assert property (instr_valid && instr_word[13:11] == 3'h3
      |=> flush_nop || skip_cond == $past(instr_word[11:10])) else $error("bit test kind wrong");
  a_addsub_flags:
    assert property (instr_valid && instr_word[13:10] == 4'hf
      |=> flush_nop || flag_update == `IDC_FLG_CDCZ) else $error("add/sub flag mask wrong");
  a_ret_lit_two:
    assert property (instr_valid && instr_word[13:10] == 4'hd
      |=> flush_nop || (two_cycle && flag_update == `IDC_FLG_NONE))
      else $error("return with literal not two cycles");
  a_standby_flags:
    assert property (op_valid && op_code inside {`IDC_OP_SLEEP, `IDC_OP_WDCLR}
      |-> flag_update == `IDC_FLG_TOPD) else $error("standby flag mask wrong");
  a_flush_follows:
    assert property (op_valid && instr_valid && (two_cycle || (skip_cond != 2'h0 && skip_taken))
      |=> flush_nop && op_code == `IDC_OP_NOP) else $error("second cycle not idle");
  a_dest_steer:
    assert property (instr_valid && instr_word[13:12] == 2'h0
      |=> flush_nop || dest_file == $past(instr_word[7])) else $error("destination wrong");
  a_unlisted_idle:
    assert property (instr_valid && instr_word[13:8] == 6'h3b |=> flush_nop
      || (op_code == `IDC_OP_NOP && flag_update == `IDC_FLG_NONE && !two_cycle))
      else $error("unlisted word not idle");
  a_rdata_idle:
    assert property (!reg_rd |=> reg_rdata == '0) else $error("read data outside read cycle");
endmodule // idc_decoder_checker
bind idc_decoder idc_decoder_checker #(.DATA_W(DATA_W)) u_chk (.core_clk, .reset_n,
  .instr_valid, .skip_taken, .reg_rd, .instr_word, .op_valid, .two_cycle, .flush_nop,
  .dest_file, .op_code, .flag_update, .skip_cond, .reg_rdata);
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the instruction decoder
`timescale 1ns/10ps
`default_nettype none
`include "idc_defines.vh"
module tb_top;
  logic        core_clk = 1'h0;
  logic        reset_n, skip_taken, reg_wr, reg_rd, req, slow, instr_valid;
  logic        op_valid, two_cycle, flush_nop, prescaler_clear, use_pin_level, dest_file;
  logic [6:0]  file_addr;
  logic [2:0]  bit_pos;
  logic [7:0]  literal;
  logic [10:0] target_addr;
  logic [13:0] req_word, instr_word;
  logic [4:0]  op_code;
  logic [3:0]  reg_addr, flag_update;
  logic [1:0]  op_class, skip_cond;
  logic [31:0] reg_wdata, reg_rdata, rv;
  int          errors = 0, samples_checked = 0, n_exec = 0, n_squash = 0;

  always #2 core_clk = ~core_clk;

  idc_decoder u_dut (.core_clk, .reset_n, .instr_word, .instr_valid, .skip_taken,
    .op_valid, .op_code, .op_class, .dest_file, .file_addr, .bit_pos, .literal,
    .target_addr, .flag_update, .skip_cond, .two_cycle, .flush_nop, .prescaler_clear,
    .use_pin_level, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  idc_pmem_model u_pmem (.core_clk, .slow, .req, .req_word, .instr_valid, .instr_word);

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked++;
      if (seen !== exp)
      begin
        errors++;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'h0;
    end
  endtask

  task rd(input [3:0] a);
    begin
      @(posedge core_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1 rv = reg_rdata;
    end
  endtask

  task issue(input [13:0] w, input s, input sl);
    begin
      @(posedge core_clk);
      req <= 1'h1;
      req_word <= w;
      skip_taken <= s;
      slow <= sl;
      @(posedge core_clk);
      req <= 1'h0;
    end
  endtask

  task wait_op;
    int k;
    begin
      k = 0;
      while (op_valid !== 1'h1 && k < 8)
      begin
        @(posedge core_clk);
        #1 k++;
      end
      chk(op_valid, 1'h1);
    end
  endtask

  // m holds {two cycles, skip true, prescaler clear, pin read}; op 1f skips the op check
  task t(input [13:0] w, input [4:0] op, input [3:0] flg, input [1:0] skp, input [3:0] m);
    logic fl;
    begin
      fl = m[3] | (m[2] & (skp != 2'h0));
      issue(w, m[2], ~slow);
      wait_op;
      if (op !== 5'h1f)
        chk(op_code, op);
      chk(op_class, w[13:12]);
      chk({file_addr, bit_pos, literal, target_addr}, {w[6:0], w[9:7], w[7:0], w[10:0]});
      chk(dest_file, w[13:12] == 2'h0 ? w[7] : w[13:11] == 3'h2);
      chk(flag_update, flg);
      chk(skip_cond, skp);
      chk({two_cycle, prescaler_clear, use_pin_level}, {m[3], m[1:0]});
      issue(14'h0000, 1'h0, slow);
      wait_op;
      chk(flush_nop, fl);
      chk(op_code, `IDC_OP_NOP);
      n_exec += 1 + !fl;
      n_squash += fl;
    end
  endtask

  // Two words back to back; the second lands in the idle slot
  task bb(input [13:0] w, input s);
    begin
      @(posedge core_clk);
      req <= 1'h1;
      req_word <= w;
      slow <= 1'h0;
      skip_taken <= s;
      @(posedge core_clk);
      req_word <= 14'h3000;
      @(posedge core_clk);
      req <= 1'h0;
      #1 chk(op_valid, 1'h1);
      @(posedge core_clk);
      skip_taken <= 1'h0;
      #1 chk(flush_nop, 1'h1);
      chk(op_code, `IDC_OP_NOP);
      n_exec += 1;
      n_squash += 1;
    end
  endtask

  initial
  begin
    reset_n = 1'h0;
    {skip_taken, reg_wr, reg_rd, req, slow} = 5'h0;
    req_word = 14'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'h1;
    repeat (3) @(posedge core_clk);
    rd(4'h1);
    chk(rv, 32'h1);
    rd(4'h2);
    chk(rv, 32'h5);
    rd(4'h3);
    chk(rv, 32'h6);
    rd(4'h9);
    chk(rv, 32'h0);
    rd(4'h0);
    chk(rv, 32'h0);
    wr(4'h0, 32'h1);
    wr(4'h5, 32'h0);
    rd(4'h0);
    chk(rv, 32'h1);
    $display("register test done");
    t(14'h0480, `IDC_OP_OR, `IDC_FLG_Z, 2'h0, 4'h0);
    t(14'h0505, `IDC_OP_AND, `IDC_FLG_Z, 2'h0, 4'h0);
    t(14'h0680, `IDC_OP_XOR, `IDC_FLG_Z, 2'h0, 4'h0);
    t(14'h0d80, `IDC_OP_RLC, `IDC_FLG_C, 2'h0, 4'h0);
    t(14'h0c00, `IDC_OP_RRC, `IDC_FLG_C, 2'h0, 4'h0);
    t(14'h0b80, `IDC_OP_DEC, `IDC_FLG_NONE, `IDC_SKP_ZERO, 4'h4);
    t(14'h0f80, `IDC_OP_INC, `IDC_FLG_NONE, `IDC_SKP_ZERO, 4'h0);
    t(14'h12a3, `IDC_OP_BCLR, `IDC_FLG_NONE, 2'h0, 4'h0);
    t(14'h16a3, `IDC_OP_BSET, `IDC_FLG_NONE, 2'h0, 4'h0);
    t(14'h1800, `IDC_OP_BTST, `IDC_FLG_NONE, `IDC_SKP_BCLR, 4'h4);
    t(14'h1c00, `IDC_OP_BTST, `IDC_FLG_NONE, `IDC_SKP_BSET, 4'h0);
    t(14'h3855, `IDC_OP_OR, `IDC_FLG_Z, 2'h0, 4'h0);
    t(14'h3900, `IDC_OP_AND, `IDC_FLG_Z, 2'h0, 4'h0);
    t(14'h3a00, `IDC_OP_XOR, `IDC_FLG_Z, 2'h0, 4'h0);
    t(14'h3c55, `IDC_OP_SUBL, `IDC_FLG_CDCZ, 2'h0, 4'h0);
    t(14'h3d00, `IDC_OP_SUBL, `IDC_FLG_CDCZ, 2'h0, 4'h0);
    t(14'h3e00, `IDC_OP_ADDL, `IDC_FLG_CDCZ, 2'h0, 4'h0);
    t(14'h3f00, `IDC_OP_ADDL, `IDC_FLG_CDCZ, 2'h0, 4'h0);
    t(14'h3400, `IDC_OP_RET, `IDC_FLG_NONE, 2'h0, 4'h8);
    t(14'h3000, `IDC_OP_LOAD, `IDC_FLG_NONE, 2'h0, 4'h0);
    t(14'h3300, `IDC_OP_LOAD, `IDC_FLG_NONE, 2'h0, 4'h0);
    t(14'h0063, `IDC_OP_SLEEP, `IDC_FLG_TOPD, 2'h0, 4'h0);
    t(14'h0064, `IDC_OP_WDCLR, `IDC_FLG_TOPD, 2'h0, 4'h0);
    t(14'h2005, `IDC_OP_CALL, `IDC_FLG_NONE, 2'h0, 4'h8);
    t(14'h2805, `IDC_OP_JUMP, `IDC_FLG_NONE, 2'h0, 4'h8);
    t(14'h0481, `IDC_OP_OR, `IDC_FLG_Z, 2'h0, 4'h2);
    t(14'h0401, `IDC_OP_OR, `IDC_FLG_Z, 2'h0, 4'h0);
    t(14'h0485, `IDC_OP_OR, `IDC_FLG_Z, 2'h0, 4'h1);
    t(14'h1006, `IDC_OP_BCLR, `IDC_FLG_NONE, 2'h0, 4'h1);
    t(14'h0101, `IDC_OP_NOP, `IDC_FLG_NONE, 2'h0, 4'h0);
    t(14'h3b00, `IDC_OP_NOP, `IDC_FLG_NONE, 2'h0, 4'h0);
    t(14'h0008, `IDC_OP_RET, `IDC_FLG_NONE, 2'h0, 4'h8);
    t(14'h0009, `IDC_OP_RETFIE, `IDC_FLG_NONE, 2'h0, 4'h8);
    t(14'h0103, `IDC_OP_CLR, `IDC_FLG_Z, 2'h0, 4'h0);
    t(14'h0081, `IDC_OP_MOVWF, `IDC_FLG_NONE, 2'h0, 4'h2);
    wr(4'h1, 32'hffa5);
    wr(4'h2, 32'h25);
    rd(4'h1);
    chk(rv, 32'h25);
    t(14'h04a5, `IDC_OP_OR, `IDC_FLG_Z, 2'h0, 4'h3);
    wr(4'h0, 32'h0);
    t(14'h04a5, `IDC_OP_OR, `IDC_FLG_Z, 2'h0, 4'h1);
    $display("decode table done");
    bb(14'h2805, 1'h0);
    bb(14'h0b80, 1'h1);
    $display("back to back done");
    rd(4'h5);
    chk(rv, n_exec);
    rd(4'h4);
    chk(rv, n_squash << 2);
    print_verdict;
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    errors++;
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
